// ### shared/mcv_pkg.sv
// Package with timing constants, modes and carrier types for the converter host controller.
package mcv_pkg;

    localparam int unsigned CLK_HZ         = 20_000_000;
    localparam int unsigned CLK_PERIOD_NS  = 1_000_000_000 / CLK_HZ;

    localparam int unsigned RESULT_W       = 10;
    localparam int unsigned CHAN_W         = 2;

    // All times round up to whole cycles, least and longest alike.
    localparam int unsigned SAMPLE_LOW_NS  = 250;
    localparam int unsigned SAMPLE_LOW_CYC = (SAMPLE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CONV_M1_NS     = 900;
    localparam int unsigned CONV_M1_CYC    = (CONV_M1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CONV_M2_NS     = 1400;
    localparam int unsigned CONV_M2_CYC    = (CONV_M2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DATA_VALID_NS  = 20;
    localparam int unsigned DATA_VALID_CYC = (DATA_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ACCESS_NS      = 60;
    localparam int unsigned ACCESS_CYC     = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RELEASE_NS     = 60;
    localparam int unsigned RELEASE_CYC    = (RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TIMER_W        = 6;
    localparam int unsigned FIFO_DEPTH     = 4;

    localparam logic [TIMER_W-1:0] TIMER_ZERO = 6'h00;
    localparam logic               MODE_SEPARATE = 1'b0;
    localparam logic               MODE_READ     = 1'b1;

    typedef enum {
        MCV_IDLE,
        MCV_SAMPLE,
        MCV_WAIT_DONE,
        MCV_SETTLE,
        MCV_READ,
        MCV_RELEASE
    } mcv_state_e;

    typedef struct packed {
        logic                channel_select_hi;
        logic                channel_select_lo;
    } mcv_chan_s;

    typedef struct packed {
        logic [CHAN_W-1:0]   channel;
        logic [RESULT_W-1:0] data;
    } mcv_result_s;

    typedef struct packed {
        logic                chip_select_b;
        logic                sample_hold_b;
        logic                read_b;
    } mcv_strobe_s;

endpackage

// ### rtl/mcv_host.sv
// Host controller that runs conversions on the multistep converter and buffers the results.
`timescale 1ns/1ps

module mcv_fifo #(
    parameter int unsigned WIDTH = 12,
    parameter int unsigned DEPTH = 4
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
            $error("FIFO depth must be a power of two, at least two.");
        end
    end

    initial begin
        if (WIDTH < 1) begin
            $error("FIFO width must be at least one bit.");
        end
    end

    // Pointers carry one extra bit so that full and empty can be told apart
    // without a separate count register; the low bits index the storage.

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;

    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;

    // Full is the wrap bits differing while the index bits agree.
    assign in_ready  = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
    assign out_valid = (wr_ptr != rd_ptr);
    assign out_data  = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
endmodule

// Behaviour
// - Host runs separate sample and read strobes, or one joined strobe.
// - Channel pins are set on the same clock edge that the sample strobe falls; 00 to 11 pick inputs 0-3.
// - Two-input variant uses only the low channel pin.
// - Host holds the sample strobe low at least 250 ns.
// - Strobes act only while chip select is low.
// - In read mode the host lowers the joined strobe to start a conversion.
module mcv_host #(
    parameter int unsigned CHANNELS = 4
) (
    input  wire logic                                   clk_sys,
    input  wire logic                                   rst_b,
    input  wire logic                                   mode_read,
    input  wire logic                                   start,
    input  wire logic        [mcv_pkg::CHAN_W-1:0]      channel,
    output logic                                        busy,
    output logic                                        timeout,
    output mcv_pkg::mcv_strobe_s                        strobes,
    output mcv_pkg::mcv_chan_s                          chan_pins,
    input  wire logic                                   done_b,
    input  wire logic        [mcv_pkg::RESULT_W-1:0]    adc_data,
    output logic                                        result_valid,
    input  wire logic                                   result_ready,
    output mcv_pkg::mcv_result_s                        result
);
    import mcv_pkg::*;

    initial begin
        if (CHANNELS != 1 && CHANNELS != 2 && CHANNELS != 4) begin
            $error("CHANNELS must be 1, 2 or 4.");
        end
    end

    // The longest dwell must fit the timer, or a wait would wrap and end early.
    initial begin
        if (CONV_M2_CYC >= (1 << TIMER_W)) begin
            $error("Timer too narrow for the longest conversion wait.");
        end
    end

    mcv_state_e               state;
    mcv_state_e               next_state;
    logic [TIMER_W-1:0]       timer;
    logic                     mode;
    logic [CHAN_W-1:0]        chan;
    logic [RESULT_W-1:0]      data;
    logic                     push;
    logic                     fifo_ready;

    // Unused channel pins are held low so the smaller variants see a clean pattern.
    wire [CHAN_W-1:0] chan_masked = (CHANNELS == 4) ? channel :
                                    (CHANNELS == 2) ? {1'b0, channel[0]} : 2'h0;
    wire timer_done  = (timer == TIMER_ZERO);
    wire done_seen   = !done_b;
    wire sample_low  = (state == MCV_SAMPLE) ||
                       (mode == MODE_READ && (state == MCV_WAIT_DONE ||
                        state == MCV_SETTLE || state == MCV_READ));
    wire read_low    = (mode == MODE_READ) ? sample_low : (state == MCV_READ);
    wire select_low  = (state != MCV_IDLE) && (state != MCV_RELEASE);
    // A start is refused while the buffer is full, so no result is dropped.
    wire can_start   = start && fifo_ready;

    // Strobes are decoded straight from the state register, so they never glitch
    // between states and change only just after a clock edge.
    assign busy            = (state != MCV_IDLE);
    assign strobes.chip_select_b = !select_low;
    assign strobes.sample_hold_b = !sample_low;
    assign strobes.read_b        = !read_low;

    // A conversion walks sample, wait for done, settle, read and release.
    // In joined-strobe mode the sample state is skipped: the single strobe
    // falls on entry to the wait and stays low until the read is over.
    // The wait is bounded by one cycle past the conversion time of the mode in use, 950 ns or 1450 ns; on expiry the bus
    // is read anyway and the timeout flag tells the consumer the word is stale.
    always_comb begin
        next_state = state;
        case (state)
            MCV_IDLE:      if (can_start) next_state = (mode_read == MODE_READ) ?
                                                       MCV_WAIT_DONE : MCV_SAMPLE;
            MCV_SAMPLE:    if (timer_done) next_state = MCV_WAIT_DONE;
            MCV_WAIT_DONE: if (done_seen || timer_done) next_state = MCV_SETTLE;
            MCV_SETTLE:    if (timer_done) next_state = MCV_READ;
            MCV_READ:      if (timer_done) next_state = MCV_RELEASE;
            MCV_RELEASE:   if (timer_done) next_state = MCV_IDLE;
            default:       next_state = MCV_IDLE;
        endcase
    end

    // Timer loads the dwell of the state being entered, counting down to zero.
    function automatic logic [TIMER_W-1:0] dwell(input mcv_state_e s, input logic m);
        case (s)
            MCV_SAMPLE:    dwell = TIMER_W'(SAMPLE_LOW_CYC - 1);
            MCV_WAIT_DONE: dwell = TIMER_W'((m == MODE_READ) ? CONV_M2_CYC : CONV_M1_CYC);
            MCV_SETTLE:    dwell = TIMER_W'(DATA_VALID_CYC);
            MCV_READ:      dwell = TIMER_W'(ACCESS_CYC);
            MCV_RELEASE:   dwell = TIMER_W'(RELEASE_CYC);
            default:       dwell = TIMER_ZERO;
        endcase
    endfunction

    // The mode pin is only trusted at the start; later dwells use the latched copy.
    wire dwell_mode = (state == MCV_IDLE) ? mode_read : mode;
    wire entering = (next_state != state);
    wire [TIMER_W-1:0] next_timer = entering ? dwell(next_state, dwell_mode) :
                                    (timer_done ? TIMER_ZERO : timer - 1'b1);
    wire capture = (state == MCV_READ) && timer_done;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state <= MCV_IDLE;
            timer <= TIMER_ZERO;
        end else begin
            state <= next_state;
            timer <= next_timer;
        end
    end

    // Per-conversion context is latched when a start is taken, so the inputs
    // may change freely while a conversion runs.
    // The captured word reaches the buffer one cycle after the read strobe
    // rises; the buffer never refuses it, because starts are held back while full.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mode    <= MODE_SEPARATE;
            chan    <= 2'h0;
            data    <= 10'h000;
            push    <= 1'b0;
            timeout <= 1'b0;
        end else begin
            push <= capture;
            if (state == MCV_IDLE && can_start) begin
                mode    <= mode_read;
                chan    <= chan_masked;
                timeout <= 1'b0;
            end
            if (state == MCV_WAIT_DONE && timer_done && !done_seen) begin
                timeout <= 1'b1;
            end
            if (capture) begin
                data <= adc_data;
            end
        end
    end

    // Channel pins are registered and stay put through the whole conversion for hold time.
    assign chan_pins.channel_select_hi = chan[1];
    assign chan_pins.channel_select_lo = chan[0];

    // Each finished conversion becomes one buffer word, channel above data.
    mcv_fifo #(
        .WIDTH (CHAN_W + RESULT_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .in_valid  (push),
        .in_ready  (fifo_ready),
        .in_data   ({chan, data}),
        .out_valid (result_valid),
        .out_ready (result_ready),
        .out_data  (result)
    );
endmodule

// ### test/mcv_conv_model.sv
// Behavioural model of the converter's digital interface.
`timescale 1ns/1ps
module mcv_conv_model (
    input wire logic                      clk_sys,
    input mcv_pkg::mcv_strobe_s           strobes,
    input mcv_pkg::mcv_chan_s             chan_pins,
    input wire logic [7:0]                extra,
    output logic                          done_b,
    output logic [mcv_pkg::RESULT_W-1:0]  adc_data
);
    import mcv_pkg::*;
    logic       sh_q = 1'b0, rd_q = 1'b0;
    logic [1:0] ch = 2'h0;
    logic [7:0] n = 8'h00;
    logic [9:0] word = 10'h000;
    int         tmr = 0;
    wire sh = !strobes.chip_select_b && !strobes.sample_hold_b;
    wire rd = !strobes.chip_select_b && !strobes.read_b;
    // A released bus shows the inverse, so a late capture cannot match by luck.
    assign adc_data = rd ? word : ~word;
    initial done_b = 1'b1;
    always @(posedge clk_sys) begin
        sh_q <= sh;
        rd_q <= rd;
        if (sh && !sh_q) begin
            ch <= {chan_pins.channel_select_hi, chan_pins.channel_select_lo};
            tmr <= rd ? 17 + extra : 0;
        end else if (!sh && sh_q && !rd_q) begin
            tmr <= 12 + extra;
        end else if (rd_q && !rd) begin
            tmr <= 0;
        end else if (tmr == 1) begin
            tmr <= 0;
            done_b <= 1'b0;
            word <= {ch, n};
            n <= n + 8'h01;
        end else if (tmr > 1) begin
            tmr <= tmr - 1;
        end
        if (rd_q && !rd) done_b <= 1'b1;
    end
endmodule

// ### test/mcv_host_monitor.sv
// Checker of the strobe sequence seen at the controller's ports.
`timescale 1ns/1ps
module mcv_host_monitor (
    input wire logic            clk_sys,
    input wire logic            rst_b,
    input wire logic            mode_read,
    input wire logic            busy,
    input mcv_pkg::mcv_strobe_s strobes,
    input mcv_pkg::mcv_chan_s   chan_pins,
    input wire logic            done_b,
    input wire logic            result_valid,
    input wire logic            result_ready,
    input mcv_pkg::mcv_result_s result
);
    import mcv_pkg::*;
    wire cs_b = strobes.chip_select_b;
    wire sh_b = strobes.sample_hold_b;
    wire rd_b = strobes.read_b;
    logic [7:0] wait_cnt;
    // A counter bounds the long wait, which a repetition could not hold.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) wait_cnt <= 8'h00;
        else wait_cnt <= (!cs_b && rd_b && done_b) ? wait_cnt + 8'h01 : 8'h00;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence s_open;
        $fell(sh_b);
    endsequence
    sequence s_held;
        !sh_b [*5];
    endsequence
    a_sample_min: assert property (s_open |-> s_held)
        else $error("sample strobe too short");
    a_strobe_gated: assert property ((!sh_b || !rd_b) |-> !cs_b)
        else $error("strobe without select");
    a_modes_apart: assert property ((!sh_b && !rd_b) |-> mode_read)
        else $error("strobes joined in separate mode");
    a_joined_fall: assert property ($fell(sh_b) && mode_read |-> $fell(rd_b))
        else $error("joined strobe split");
    a_chan_steady: assert property ((!sh_b && !$fell(sh_b)) |-> $stable(chan_pins))
        else $error("channel moved while sampling");
    a_read_follows: assert property ($fell(done_b) && !mode_read |-> ##[1:6] !rd_b)
        else $error("no read after done");
    a_idle_quiet: assert property (!busy |-> cs_b && sh_b && rd_b)
        else $error("strobe while idle");
    a_wait_bound: assert property (wait_cnt <= 8'h1B)
        else $error("wait for done too long");
    a_result_held: assert property (result_valid && !result_ready |=> $stable(result))
        else $error("result changed while held");
endmodule
bind mcv_host mcv_host_monitor mon (.clk_sys, .rst_b, .mode_read, .busy, .strobes,
    .chan_pins, .done_b, .result_valid, .result_ready, .result);

// ### test/mcv_host_bench.sv
// Self-checking bench for the converter host controller.
`timescale 1ns/1ps
module mcv_host_bench;
    import mcv_pkg::*;
    logic clk_sys, rst_b, mode_read, start, result_ready, done_b, busy, timeout, result_valid;
    logic [1:0] channel;
    logic [9:0] adc_data, last;
    logic [7:0] extra, n;
    mcv_strobe_s strobes;
    mcv_chan_s chan_pins;
    mcv_result_s result;
    int err_total, samples_checked;
    mcv_host dut (.clk_sys, .rst_b, .mode_read, .start, .channel, .busy, .timeout, .strobes,
        .chan_pins, .done_b, .adc_data, .result_valid, .result_ready, .result);
    mcv_conv_model conv (.clk_sys, .strobes, .chan_pins, .extra, .done_b, .adc_data);
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic run(input logic md, input logic [1:0] ch, input logic taken);
        for (int i = 0; i < 100 && busy !== 1'b0; i++) @(posedge clk_sys) #5;
        mode_read = md;
        channel = ch;
        start = 1'b1;
        @(posedge clk_sys) #5;
        start = 1'b0;
        check({11'h000, busy}, {11'h000, taken});
    endtask
    task automatic pop(input logic [11:0] exp, input logic to);
        for (int i = 0; i < 200 && result_valid !== 1'b1; i++) @(posedge clk_sys) #5;
        check(result, exp);
        check({11'h000, timeout}, {11'h000, to});
        result_ready = 1'b1;
        @(posedge clk_sys) #5;
        result_ready = 1'b0;
    endtask
    task automatic conv_one(input logic md, input logic [1:0] ch);
        run(md, ch, 1'b1);
        pop({ch, ch, n}, 1'b0);
        last = {ch, n};
        n++;
    endtask
    task automatic t_separate;
        for (int c = 0; c < 4; c++) conv_one(1'b0, 2'(c));
    endtask
    task automatic t_joined;
        for (int c = 3; c >= 0; c--) conv_one(1'b1, 2'(c));
    endtask
    task automatic t_timeout;
        extra = 8'h1E;
        run(1'b0, 2'h2, 1'b1);
        pop({2'h2, last}, 1'b1);
        extra = 8'h00;
        conv_one(1'b0, 2'h1);
    endtask
    task automatic t_full;
        for (int k = 0; k < 4; k++) run(1'b0, 2'(k), 1'b1);
        run(1'b0, 2'h0, 1'b0);
        for (int k = 0; k < 4; k++) begin
            pop({2'(k), 2'(k), n}, 1'b0);
            n++;
        end
    endtask
    initial begin
        rst_b = 1'b0;
        mode_read = 1'b0;
        start = 1'b0;
        channel = 2'h0;
        result_ready = 1'b0;
        extra = 8'h00;
        n = 8'h00;
        last = 10'h000;
        err_total = 0;
        samples_checked = 0;
        repeat (16) @(posedge clk_sys);
        #5 rst_b = 1'b1;
        t_separate;
        t_joined;
        t_timeout;
        t_full;
        results;
    end
    // Fourteen conversions of under 60 cycles each fit well inside this span.
    initial begin
        #200_000;
        err_total++;
        results;
    end
endmodule
